/* core/eie_exec.sv */
// Design decisions made here: register access over Wishbone and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - A5H first byte escapes; next byte selects
// - wide shift right keeps bit 39, flags untouched
// - break with debug enabled halts to debugger
// - break without debug: two-byte nop, pc+2
// - compare indirect RAM, branch on unequal
// - carry set when accumulator below RAM byte
// - wide clear zeroes all 40 bits
// - increment unselected pointer modulo 65536
// - low byte rollover carries into high byte
// - select zero targets second, one first pointer
// - pointer increment: two bytes, three cycles
// - pc-relative jump: pc+2 plus unsigned accumulator
// - wide shift left fills bit zero with 0
// - code load at unselected pointer plus accumulator
module eie_exec (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_nrst,
   // instruction issue from the core
   input wire logic i_ins_valid,
   input wire logic [7:0] i_ins_byte,
   input wire logic [15:0] i_pc,
   // core architectural state
   input wire logic [7:0] i_acc,
   input wire logic i_pointer_select,
   input wire logic [15:0] i_pointer_first,
   input wire logic [15:0] i_pointer_second,
   input wire logic [7:0] i_r0,
   input wire logic [7:0] i_r1,
   // program memory, one cycle read latency
   output logic o_pm_rd,
   output logic [15:0] o_pm_addr,
   input wire logic [7:0] i_pm_data,
   // internal RAM, one cycle read latency
   output logic o_ram_rd,
   output logic [7:0] o_ram_addr,
   input wire logic [7:0] i_ram_data,
   // results back to the core
   output logic o_busy,
   output logic o_done,
   output logic o_escape,
   output logic [15:0] o_pc_next,
   output logic o_acc_we,
   output logic [7:0] o_acc_wdata,
   output logic o_carry_we,
   output logic o_carry_wdata,
   output logic o_pointer_first_we,
   output logic o_pointer_second_we,
   output logic [15:0] o_pointer_wdata,
   output logic o_debug_halt,
   output logic [eie_pkg::WACC_W-1:0] o_wide_acc,
   // wishbone classic slave
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [7:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack
);
   import eie_pkg::*;

   typedef struct packed {
      eie_state_t st;
      logic [15:0] pc;
      logic [7:0] acc;
      logic pointer_select;
      logic [15:0] alt;
      logic [7:0] r0;
      logic [7:0] r1;
      logic [39:0] wacc;
      logic pm_rd;
      logic [15:0] pm_addr;
      logic ram_rd;
      logic [7:0] ram_addr;
      logic [15:0] pc_wd;
      logic acc_we;
      logic [7:0] acc_wd;
      logic carry_we;
      logic carry_wd;
      logic dp_first_we;
      logic dp_second_we;
      logic [15:0] dp_wd;
      logic halted;
      logic dbg_en;
      logic [7:0] last_op;
      logic wb_ack;
      logic [31:0] wb_dat;
   } eie_regs_t;

   eie_regs_t r;
   eie_regs_t n;
   logic wb_hit;
   logic [7:0] rel;

   // ********************************
   // byte-lane merge for bus writes
   // ********************************
   function automatic logic [31:0] eie_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] sel);
      logic [31:0] res;
      res = old_v;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            res[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return res;
   endfunction : eie_merge

   // ********************************
   // next-state logic
   // ********************************
   always_comb begin
      n = r;
      rel = i_pm_data;
      wb_hit = i_wb_cyc && i_wb_stb && !r.wb_ack;
      n.wb_ack = wb_hit;
      n.pm_rd = 1'b0;
      n.ram_rd = 1'b0;
      // bus access first so that the instruction below wins on the wide accumulator
      if (wb_hit) begin
         n.wb_dat = 32'h0000_0000;
         case (i_wb_adr)
            REG_CTRL: begin
               n.wb_dat[CTRL_DBG_EN] = r.dbg_en;
               if (i_wb_we && i_wb_sel[0]) begin
                  n.dbg_en = i_wb_dat[CTRL_DBG_EN];
               end
            end
            REG_STATUS: begin
               n.wb_dat[STAT_BUSY] = (r.st != ST_IDLE);
               n.wb_dat[STAT_HALT] = r.halted;
               n.wb_dat[STAT_OP_LSB +: 8] = r.last_op;
               // writing one releases a debug halt
               if (i_wb_we && i_wb_sel[0] && i_wb_dat[STAT_HALT]) begin
                  n.halted = 1'b0;
               end
            end
            REG_WACC_LO: begin
               n.wb_dat = r.wacc[31:0];
               if (i_wb_we) begin
                  n.wacc[31:0] = eie_merge(r.wacc[31:0], i_wb_dat, i_wb_sel);
               end
            end
            REG_WACC_HI: begin
               n.wb_dat[7:0] = r.wacc[39:32];
               if (i_wb_we && i_wb_sel[0]) begin
                  n.wacc[39:32] = i_wb_dat[7:0];
               end
            end
            default: begin
               n.wb_dat = 32'h0000_0000;
            end
         endcase
      end
      unique case (r.st)
         ST_IDLE: begin
            if (i_ins_valid && i_ins_byte == OP_ESCAPE) begin
               n.pc = i_pc;
               n.acc = i_acc;
               n.pointer_select = i_pointer_select;
               n.alt = i_pointer_select ? i_pointer_first : i_pointer_second;
               n.r0 = i_r0;
               n.r1 = i_r1;
               n.pm_addr = i_pc + PC_STEP1;
               n.pm_rd = 1'b1;
               n.acc_we = 1'b0;
               n.carry_we = 1'b0;
               n.dp_first_we = 1'b0;
               n.dp_second_we = 1'b0;
               n.st = ST_OP2;
            end
         end
         ST_OP2: begin
            n.last_op = i_pm_data;
            n.pc_wd = r.pc + PC_STEP2;
            n.st = ST_DONE;
            case (i_pm_data)
               OP_SHR: begin
                  n.wacc = {r.wacc[39], r.wacc[39:1]};
               end
               OP_SHL: begin
                  n.wacc = {r.wacc[38:0], 1'b0};
               end
               OP_CLR: begin
                  n.wacc = 40'h00_0000_0000;
               end
               OP_INC_ALT: begin
                  // full 16-bit add carries a low byte rollover upward
                  n.dp_wd = r.alt + PTR_STEP;
                  n.dp_first_we = r.pointer_select;
                  n.dp_second_we = !r.pointer_select;
                  n.st = ST_WAIT;
               end
               OP_JMP_PC: begin
                  n.pc_wd = r.pc + PC_STEP2 + {8'h00, r.acc};
               end
               OP_CMP_R0, OP_CMP_R1: begin
                  n.ram_addr = i_pm_data[0] ? r.r1 : r.r0;
                  n.ram_rd = 1'b1;
                  n.pm_addr = r.pc + PC_STEP2;
                  n.pm_rd = 1'b1;
                  n.st = ST_CMP;
               end
               OP_CODE_LD: begin
                  n.pm_addr = r.alt + {8'h00, r.acc};
                  n.pm_rd = 1'b1;
                  n.st = ST_CODE;
               end
               OP_BREAK: begin
                  if (r.dbg_en) begin
                     n.halted = 1'b1;
                     n.st = ST_HALT;
                  end
               end
               default: begin
                  n.st = ST_DONE;
               end
            endcase
         end
         ST_CMP: begin
            n.carry_we = 1'b1;
            n.carry_wd = r.acc < i_ram_data;
            if (r.acc != i_ram_data) begin
               n.pc_wd = r.pc + PC_STEP3 + {{8{rel[7]}}, rel};
            end else begin
               n.pc_wd = r.pc + PC_STEP3;
            end
            n.st = ST_DONE;
         end
         ST_CODE: begin
            n.acc_we = 1'b1;
            n.acc_wd = i_pm_data;
            n.st = ST_DONE;
         end
         ST_WAIT: begin
            n.st = ST_DONE;
         end
         ST_HALT: begin
            // resume at the instruction after the breakpoint
            if (!r.halted) begin
               n.st = ST_DONE;
            end
         end
         ST_DONE: begin
            n.st = ST_IDLE;
         end
         default: begin
            n.st = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         r <= '0;
         r.st <= ST_IDLE;
         r.dbg_en <= CTRL_DBG_RST;
      end else begin
         r <= n;
      end
   end

   // ********************************
   // outputs
   // ********************************
   assign o_busy = (r.st != ST_IDLE);
   assign o_done = (r.st == ST_DONE);
   assign o_escape = (r.st == ST_IDLE) && i_ins_valid && (i_ins_byte == OP_ESCAPE);
   assign o_pc_next = r.pc_wd;
   assign o_acc_we = o_done && r.acc_we;
   assign o_acc_wdata = r.acc_wd;
   assign o_carry_we = o_done && r.carry_we;
   assign o_carry_wdata = r.carry_wd;
   assign o_pointer_first_we = o_done && r.dp_first_we;
   assign o_pointer_second_we = o_done && r.dp_second_we;
   assign o_pointer_wdata = r.dp_wd;
   assign o_debug_halt = r.halted;
   assign o_wide_acc = r.wacc;
   assign o_pm_rd = r.pm_rd;
   assign o_pm_addr = r.pm_addr;
   assign o_ram_rd = r.ram_rd;
   assign o_ram_addr = r.ram_addr;
   assign o_wb_dat = r.wb_dat;
   assign o_wb_ack = r.wb_ack;

   // ********************************
   // checks
   // ********************************
   escape_only_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (r.st == ST_IDLE && !(i_ins_valid && i_ins_byte == OP_ESCAPE)) |=> r.st == ST_IDLE)
      else $error("non-escape byte started an extended operation");
   shift_right_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (r.st == ST_OP2 && i_pm_data == OP_SHR) |=> r.wacc == {$past(r.wacc[39]), $past(r.wacc[39:1])})
      else $error("arithmetic shift right wrong");
   break_halt_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (r.st == ST_OP2 && i_pm_data == OP_BREAK && r.dbg_en) |=> o_debug_halt && r.st == ST_HALT)
      else $error("breakpoint did not halt");
   break_nop_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (r.st == ST_OP2 && i_pm_data == OP_BREAK && !r.dbg_en) |=>
      o_done && !o_debug_halt && o_pc_next == $past(r.pc) + PC_STEP2 && !o_carry_we)
      else $error("disabled breakpoint is not a two-byte nop");
   cmp_branch_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (r.st == ST_CMP && r.acc != i_ram_data) |=>
      o_done && !o_acc_we && o_pc_next == $past(r.pc) + PC_STEP3 + {{8{$past(rel[7])}}, $past(rel)})
      else $error("compare branch target wrong");
   cmp_carry_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (r.st == ST_CMP) |=> o_carry_we && o_carry_wdata == ($past(r.acc) < $past(i_ram_data)))
      else $error("compare carry wrong");
   wide_clear_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (r.st == ST_OP2 && i_pm_data == OP_CLR) |=> r.wacc == 40'h00_0000_0000)
      else $error("wide clear left bits set");
   ptr_inc_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (r.st == ST_OP2 && i_pm_data == OP_INC_ALT) |=> !o_done ##1
      (o_done && o_pointer_wdata == $past(r.alt, 2) + PTR_STEP &&
       o_pointer_first_we == $past(r.pointer_select, 2) && o_pointer_second_we == !$past(r.pointer_select, 2)))
      else $error("alternate pointer increment wrong");
   pc_jump_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (r.st == ST_OP2 && i_pm_data == OP_JMP_PC) |=>
      o_done && !o_acc_we && o_pc_next == $past(r.pc) + PC_STEP2 + {8'h00, $past(r.acc)})
      else $error("pc relative jump target wrong");
   shift_left_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (r.st == ST_OP2 && i_pm_data == OP_SHL) |=> r.wacc == {$past(r.wacc[38:0]), 1'b0})
      else $error("logical shift left wrong");
   code_load_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (r.st == ST_OP2 && i_pm_data == OP_CODE_LD) |=>
      o_pm_rd && o_pm_addr == $past(r.alt) + {8'h00, $past(r.acc)} ##1 r.st == ST_DONE && o_acc_we)
      else $error("code load address wrong");
endmodule : eie_exec
`default_nettype wire

/* core/eie_pkg.sv */
package eie_pkg;
   // ********************************
   // instruction encodings
   // ********************************
   localparam logic [7:0] OP_ESCAPE = 8'hA5;
   localparam logic [7:0] OP_BREAK = 8'h00;
   localparam logic [7:0] OP_SHR = 8'h03;
   localparam logic [7:0] OP_SHL = 8'h23;
   localparam logic [7:0] OP_CLR = 8'hE4;
   localparam logic [7:0] OP_INC_ALT = 8'hA3;
   localparam logic [7:0] OP_JMP_PC = 8'h73;
   localparam logic [7:0] OP_CMP_R0 = 8'hB6;
   localparam logic [7:0] OP_CMP_R1 = 8'hB7;
   localparam logic [7:0] OP_CODE_LD = 8'h93;

   // ********************************
   // program counter steps and widths
   // ********************************
   localparam logic [15:0] PC_STEP1 = 16'h0001;
   localparam logic [15:0] PC_STEP2 = 16'h0002;
   localparam logic [15:0] PC_STEP3 = 16'h0003;
   localparam logic [15:0] PTR_STEP = 16'h0001;
   localparam int WACC_W = 40;

   // ********************************
   // register map (byte addresses)
   // ********************************
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_WACC_LO = 8'h08;
   localparam logic [7:0] REG_WACC_HI = 8'h0C;
   localparam int CTRL_DBG_EN = 0;
   localparam int STAT_BUSY = 0;
   localparam int STAT_HALT = 1;
   localparam int STAT_OP_LSB = 8;
   localparam logic CTRL_DBG_RST = 1'b0;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_OP2 = 3'b001,
      ST_CMP = 3'b010,
      ST_CODE = 3'b011,
      ST_WAIT = 3'b100,
      ST_DONE = 3'b101,
      ST_HALT = 3'b110
   } eie_state_t;
endpackage : eie_pkg

/* testbench/eie_mem_model.sv */
`timescale 1ns/10ps
`default_nettype none
module eie_mem_model (
   // clock
   input wire logic i_clk,
   // program memory port
   input wire logic i_pm_rd,
   input wire logic [15:0] i_pm_addr,
   output logic [7:0] o_pm_data,
   // internal ram port
   input wire logic i_ram_rd,
   input wire logic [7:0] i_ram_addr,
   output logic [7:0] o_ram_data
);
   logic [7:0] mem [0:65535];
   logic [7:0] ram [0:255];
   logic [7:0] pm_last = 8'h00;
   logic [7:0] ram_last = 8'h00;
   // ****************
   // read path
   // ****************
   // data stands within the strobe cycle, since the block samples it at the edge closing that cycle;
   // idle lines show the inverse of the last answer so stale data never passes for an answer
   assign o_pm_data = i_pm_rd ? mem[i_pm_addr] : ~pm_last;
   assign o_ram_data = i_ram_rd ? ram[i_ram_addr] : ~ram_last;
   always @(posedge i_clk) begin
      if (i_pm_rd) pm_last <= mem[i_pm_addr];
      if (i_ram_rd) ram_last <= ram[i_ram_addr];
   end
endmodule : eie_mem_model
`default_nettype wire

/* testbench/extended_instruction_exec_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module extended_instruction_exec_tb_top;
   import eie_pkg::*;
   logic i_clk, i_nrst, i_ins_valid, i_pointer_select, i_wb_cyc, i_wb_stb, i_wb_we;
   logic [7:0] i_ins_byte, i_acc, i_r0, i_r1, i_wb_adr, i_pm_data, i_ram_data, o_ram_addr, o_acc_wdata, aw;
   logic [15:0] i_pc, i_pointer_first, i_pointer_second, o_pm_addr, o_pc_next, o_pointer_wdata, pw;
   logic [3:0] i_wb_sel;
   logic [31:0] i_wb_dat, o_wb_dat, rd;
   logic o_pm_rd, o_ram_rd, o_busy, o_done, o_acc_we, o_carry_we, o_carry_wdata, cw;
   logic o_pointer_first_we, o_pointer_second_we, o_debug_halt, o_wb_ack, o_escape, esc;
   logic [39:0] o_wide_acc;
   logic [19:0] res;
   int n_errors, total_checks, n_cyc, sh_cyc, cycles;

   eie_exec DUT (.i_clk(i_clk), .i_nrst(i_nrst), .i_ins_valid(i_ins_valid), .i_ins_byte(i_ins_byte),
      .i_pc(i_pc), .i_acc(i_acc), .i_pointer_select(i_pointer_select), .i_pointer_first(i_pointer_first),
      .i_pointer_second(i_pointer_second), .i_r0(i_r0), .i_r1(i_r1), .o_pm_rd(o_pm_rd), .o_pm_addr(o_pm_addr),
      .i_pm_data(i_pm_data), .o_ram_rd(o_ram_rd), .o_ram_addr(o_ram_addr), .i_ram_data(i_ram_data),
      .o_busy(o_busy), .o_done(o_done), .o_escape(o_escape), .o_pc_next(o_pc_next), .o_acc_we(o_acc_we),
      .o_acc_wdata(o_acc_wdata), .o_carry_we(o_carry_we), .o_carry_wdata(o_carry_wdata),
      .o_pointer_first_we(o_pointer_first_we), .o_pointer_second_we(o_pointer_second_we),
      .o_pointer_wdata(o_pointer_wdata), .o_debug_halt(o_debug_halt), .o_wide_acc(o_wide_acc),
      .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel),
      .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack));
   eie_mem_model MM (.i_clk(i_clk), .i_pm_rd(o_pm_rd), .i_pm_addr(o_pm_addr), .o_pm_data(i_pm_data),
      .i_ram_rd(o_ram_rd), .i_ram_addr(o_ram_addr), .o_ram_data(i_ram_data));

   // ****************
   // helpers
   // ****************
   always #5 i_clk = ~i_clk;
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         tally_and_finish();
      end
   end
   task tally_and_finish;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : tally_and_finish
   task chk(input logic [47:0] g, input logic [47:0] e);
      total_checks++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   // outputs are read at the edge itself: registered values are still the pre-edge ones
   task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_wb_cyc <= 1'b1;
      i_wb_stb <= 1'b1;
      i_wb_we <= we;
      i_wb_adr <= a;
      i_wb_dat <= d;
      // this wait ends when o_wb_ack rises; the bench timeout ends it only if no ack comes
      do begin
         @(posedge i_clk);
      end while (o_wb_ack !== 1'b1);
      rd = o_wb_dat;
      i_wb_cyc <= 1'b0;
      i_wb_stb <= 1'b0;
      i_wb_we <= 1'b0;
   endtask : wb
   task issue(input logic [7:0] b, input logic [15:0] pc, input logic [7:0] acc, input logic sel,
              input logic [15:0] p0, input logic [15:0] p1);
      @(posedge i_clk);
      i_ins_valid <= 1'b1;
      i_ins_byte <= b;
      i_pc <= pc;
      i_acc <= acc;
      i_pointer_select <= sel;
      i_pointer_first <= p0;
      i_pointer_second <= p1;
      @(posedge i_clk);
      esc = o_escape;
      i_ins_valid <= 1'b0;
   endtask : issue
   task wait_done;
      for (n_cyc = 1; n_cyc < 40; n_cyc++) begin
         @(posedge i_clk);
         if (o_done === 1'b1) break;
      end
      if (n_cyc == 40) n_errors++;
      res = {o_pc_next, o_acc_we, o_carry_we, o_pointer_first_we, o_pointer_second_we};
      aw = o_acc_wdata;
      cw = o_carry_wdata;
      pw = o_pointer_wdata;
   endtask : wait_done
   task ex(input logic [7:0] b2, input logic [15:0] pc, input logic [7:0] acc, input logic sel,
           input logic [15:0] p0, input logic [15:0] p1);
      MM.mem[pc + 16'h0001] = b2;
      issue(OP_ESCAPE, pc, acc, sel, p0, p1);
      wait_done();
   endtask : ex
   task load_m(input logic [39:0] v);
      wb(1'b1, REG_WACC_LO, v[31:0]);
      wb(1'b1, REG_WACC_HI, {24'h000000, v[39:32]});
   endtask : load_m

   // ****************
   // scenarios
   // ****************
   task t_regs;
      wb(1'b0, REG_CTRL, 32'h00000000);
      chk(rd, 32'h00000000);
      wb(1'b0, 8'h10, 32'h00000000);
      chk(rd, 32'h00000000);
      load_m(40'hC5B1A29384);
      wb(1'b0, REG_WACC_HI, 32'h00000000);
      chk(rd[7:0], 8'hC5);
   endtask : t_regs
   task t_wide;
      ex(OP_SHR, 16'h0100, 8'h12, 1'b0, 16'h0000, 16'h0000);
      sh_cyc = n_cyc;
      chk(esc, 1'b1);
      chk(o_wide_acc, 40'hE2D8D149C2);
      chk(res, {16'h0102, 4'h0});
      load_m(40'h4000000001);
      ex(OP_SHR, 16'h0100, 8'h12, 1'b0, 16'h0000, 16'h0000);
      chk(o_wide_acc, 40'h2000000000);
      load_m(40'hC5B1A29384);
      ex(OP_SHL, 16'h0110, 8'h12, 1'b0, 16'h0000, 16'h0000);
      chk(o_wide_acc, 40'h8B63452708);
      chk(res, {16'h0112, 4'h0});
      ex(OP_CLR, 16'h0120, 8'h12, 1'b0, 16'h0000, 16'h0000);
      chk(o_wide_acc, 40'h0000000000);
      chk(res, {16'h0122, 4'h0});
   endtask : t_wide
   task t_break;
      int k;
      ex(OP_BREAK, 16'h0300, 8'h00, 1'b0, 16'h0000, 16'h0000);
      chk({res, o_debug_halt}, {16'h0302, 4'h0, 1'b0});
      wb(1'b1, REG_CTRL, 32'h00000001);
      MM.mem[16'h0401] = OP_BREAK;
      issue(OP_ESCAPE, 16'h0400, 8'h00, 1'b0, 16'h0000, 16'h0000);
      for (k = 0; k < 20 && o_debug_halt !== 1'b1; k++) @(posedge i_clk);
      wb(1'b0, REG_STATUS, 32'h00000000);
      chk({rd[STAT_HALT], rd[15:8]}, {1'b1, OP_BREAK});
      wb(1'b1, REG_STATUS, 32'h00000002);
      wait_done();
      chk(res, {16'h0402, 4'h0});
      wb(1'b1, REG_CTRL, 32'h00000000);
   endtask : t_break
   task t_inc;
      ex(OP_INC_ALT, 16'h0500, 8'h00, 1'b0, 16'hAAAA, 16'h12FE);
      chk({res, pw}, {16'h0502, 4'h1, 16'h12FF});
      chk(n_cyc, sh_cyc + 1);
      ex(OP_INC_ALT, 16'h0500, 8'h00, 1'b0, 16'hAAAA, 16'h12FF);
      chk(pw, 16'h1300);
      ex(OP_INC_ALT, 16'h0500, 8'h00, 1'b1, 16'hFFFF, 16'h5555);
      chk({res, pw}, {16'h0502, 4'h2, 16'h0000});
   endtask : t_inc
   task t_cmp;
      logic [7:0] av [4] = '{8'h34, 8'h56, 8'h80, 8'h00};
      logic [7:0] mv [4] = '{8'h56, 8'h56, 8'h12, 8'h01};
      logic [7:0] rl [4] = '{8'h10, 8'h10, 8'hF0, 8'hF0};
      logic [15:0] tgt;
      for (int i = 0; i < 4; i++) begin
         MM.ram[8'h78] = (i < 2) ? mv[i] : ~mv[i];
         MM.ram[8'h79] = (i < 2) ? ~mv[i] : mv[i];
         MM.mem[16'h0202] = rl[i];
         tgt = (av[i] == mv[i]) ? 16'h0203 : 16'h0203 + {{8{rl[i][7]}}, rl[i]};
         ex((i < 2) ? OP_CMP_R0 : OP_CMP_R1, 16'h0200, av[i], 1'b0, 16'h0000, 16'h0000);
         chk(res, {tgt, 4'b0100});
         chk(cw, av[i] < mv[i]);
         chk(o_ram_addr, (i < 2) ? 8'h78 : 8'h79);
      end
   endtask : t_cmp
   task t_misc;
      ex(OP_JMP_PC, 16'h10FE, 8'hF0, 1'b0, 16'h0000, 16'h0000);
      chk(res, {16'h11F0, 4'h0});
      MM.mem[16'h0100] = 8'h77;
      MM.mem[16'h2100] = 8'h99;
      ex(OP_CODE_LD, 16'h0600, 8'h01, 1'b0, 16'h3000, 16'h00FF);
      chk({res, aw}, {16'h0602, 4'h8, 8'h77});
      chk(o_pm_addr, 16'h0100);
      ex(OP_CODE_LD, 16'h0600, 8'h01, 1'b1, 16'h20FF, 16'h0000);
      chk({res, aw}, {16'h0602, 4'h8, 8'h99});
      ex(8'h55, 16'h0700, 8'h01, 1'b0, 16'h0000, 16'h0000);
      chk(res, {16'h0702, 4'h0});
      issue(8'h73, 16'h0800, 8'h00, 1'b0, 16'h0000, 16'h0000);
      chk(esc, 1'b0);
      @(posedge i_clk);
      chk(o_busy, 1'b0);
   endtask : t_misc

   initial begin
      {i_clk, i_nrst, i_ins_valid, i_pointer_select, i_wb_cyc, i_wb_stb, i_wb_we} = '0;
      {i_ins_byte, i_acc, i_wb_adr, i_pc, i_pointer_first, i_pointer_second, i_wb_dat} = '0;
      i_r0 = 8'h78;
      i_r1 = 8'h79;
      i_wb_sel = 4'hF;
      repeat (8) @(posedge i_clk);
      i_nrst <= 1'b1;
      t_regs();
      t_wide();
      t_break();
      t_inc();
      t_cmp();
      t_misc();
      tally_and_finish();
   end
endmodule : extended_instruction_exec_tb_top
`default_nettype wire
